// ---- rtl/cdwe_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cdwe_defs.vh"

// Notes on behaviour
// (RULE_01) Complement op writes inverted file register to destination, updates zero.
// (RULE_02) Destination bit 0 targets the accumulator, 1 the file register.
// (RULE_03) Watchdog clear op zeroes the watchdog counter in one cycle.
// (RULE_04) Watchdog clear op zeroes the prescaler together with the counter.
// (RULE_05) Watchdog clear op sets timeout and powerdown flags to one.
// (RULE_06) Decrement op subtracts one, writes destination, updates zero, one cycle; code retires in ST_EXEC, two cycles after issue.
// (RULE_07) Decrement-skip op subtracts one, writes destination, touches no flag.
// (RULE_08) Decrement-skip with zero result runs a no-operation cycle instead.
// (RULE_09) Decrement-skip with non-zero result finishes after one cycle; code retires in ST_EXEC, two cycles after issue.
// (RULE_10) Zero flag is set for a zero 8-bit result, cleared otherwise.
module cdwe_top #(
  parameter PRE_W = `CDWE_PRE_W,
  parameter WDOG_W = `CDWE_WDOG_W
) (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  output wire instrRetire,
  output wire skipNop,
  output wire zeroFlag,
  output wire timeoutFlag,
  output wire powerdownFlag
);

  localparam AW = `CDWE_FADDR_W;
  localparam DW = `CDWE_DATA_W;

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_READ = 4'h2;
  localparam [3:0] ST_EXEC = 4'h4;
  localparam [3:0] ST_NOP = 4'h8;

  // Reset release through two flops
  reg rstSync1_q;
  reg rstSync2_q;
  wire rstN;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  assign rstN = rstSync2_q;

  // Bus and core state
  reg hreadyout_q;
  reg hreadyout_d;
  reg [31:0] hrdata_q;
  reg [31:0] hrdata_d;
  reg hresp_q;
  reg dpWrite_q;
  reg dpWrite_d;
  reg [31:0] dpAddr_q;
  reg [31:0] dpAddr_d;
  reg [1:0] rdCnt_q;
  reg [1:0] rdCnt_d;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [13:0] instr_q;
  reg [13:0] instr_d;
  reg [DW-1:0] wReg_q;
  reg [DW-1:0] wReg_d;
  reg [AW-1:0] fileAddr_q;
  reg [AW-1:0] fileAddr_d;
  reg zero_q;
  reg zero_d;
  reg tout_q;
  reg tout_d;
  reg pdown_q;
  reg pdown_d;
  reg retire_q;
  reg retire_d;
  reg skipNop_q;
  reg lastSkip_q;
  reg lastSkip_d;
  reg [7:0] retireCnt_q;
  reg [7:0] retireCnt_d;

  // Execution data path signals
  reg memWe;
  reg [AW-1:0] memWaddr;
  reg [DW-1:0] memWdata;
  reg [DW-1:0] result;
  reg wdogClear;
  wire [AW-1:0] memRaddr;
  wire [DW-1:0] memRdata;
  wire [PRE_W-1:0] wdogPre;
  wire [WDOG_W-1:0] wdogCnt;
  wire accept;
  wire wordOk;
  wire wrDo;
  wire start;
  wire [5:0] opcNew;
  wire [5:0] opc;
  wire dest;

  assign accept = hsel & htrans[1] & hready;
  assign wordOk = (hsize == `CDWE_HSIZE_WORD);
  assign wrDo = dpWrite_q & hreadyout_q;
  assign start = wrDo & (dpAddr_q == `CDWE_ADDR_INSTR) &
                 (state_q == ST_IDLE);
  assign opcNew = hwdata[`CDWE_OPC_HI:`CDWE_OPC_LO];
  assign opc = instr_q[`CDWE_OPC_HI:`CDWE_OPC_LO];
  assign dest = instr_q[`CDWE_DEST_BIT];
  assign memRaddr = (state_q == ST_READ) ? instr_q[AW-1:0] : fileAddr_q;

  cdwe_file_mem #(
    .ADDR_W(AW),
    .DATA_W(DW)
  ) u_mem (
    .clk(clk),
    .wrEn(memWe),
    .wrAddr(memWaddr),
    .wrData(memWdata),
    .rdAddr(memRaddr),
    .rdData(memRdata)
  );

  cdwe_watchdog #(
    .PRE_W(PRE_W),
    .CNT_W(WDOG_W)
  ) u_wdog (
    .clk(clk),
    .rstN(rstN),
    .clear(wdogClear),
    .prescale(wdogPre),
    .count(wdogCnt)
  );

  // Instruction sequencer
  always @* begin
    state_d = state_q;
    instr_d = instr_q;
    wReg_d = wReg_q;
    zero_d = zero_q;
    tout_d = tout_q;
    pdown_d = pdown_q;
    retire_d = 1'b0;
    lastSkip_d = lastSkip_q;
    wdogClear = 1'b0;
    memWe = 1'b0;
    memWaddr = fileAddr_q;
    memWdata = hwdata[DW-1:0];
    result = {DW{1'b0}};
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          instr_d = hwdata[13:0];
          if (hwdata[13:0] == `CDWE_OPC_WDCLR) begin
            wdogClear = 1'b1; // RULE_03 RULE_04
            tout_d = 1'b1; // RULE_05
            pdown_d = 1'b1; // RULE_05
            retire_d = 1'b1; // RULE_03
          end else if (opcNew == `CDWE_OPC_COMPL ||
                       opcNew == `CDWE_OPC_DEC ||
                       opcNew == `CDWE_OPC_DECSKIP) begin
            state_d = ST_READ;
          end else begin
            retire_d = 1'b1;
          end
        end
      end
      ST_READ: begin
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        if (opc == `CDWE_OPC_COMPL) begin
          result = ~memRdata; // RULE_01
        end else begin
          result = memRdata - {{(DW-1){1'b0}}, 1'b1}; // RULE_06 RULE_07
        end
        if (dest) begin
          memWe = 1'b1; // RULE_02
          memWaddr = instr_q[AW-1:0];
          memWdata = result;
        end else begin
          wReg_d = result; // RULE_02
        end
        if (opc != `CDWE_OPC_DECSKIP) begin
          zero_d = (result == {DW{1'b0}}); // RULE_01 RULE_06 RULE_10
          lastSkip_d = 1'b0;
          retire_d = 1'b1;
          state_d = ST_IDLE;
        end else if (result == {DW{1'b0}}) begin
          lastSkip_d = 1'b1;
          state_d = ST_NOP; // RULE_08
        end else begin
          lastSkip_d = 1'b0;
          retire_d = 1'b1; // RULE_09
          state_d = ST_IDLE;
        end
      end
      ST_NOP: begin
        retire_d = 1'b1; // RULE_08
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (wrDo && state_q == ST_IDLE) begin
      if (dpAddr_q == `CDWE_ADDR_WREG) begin
        wReg_d = hwdata[DW-1:0];
      end
      if (dpAddr_q == `CDWE_ADDR_STATUS) begin
        zero_d = hwdata[`CDWE_ST_ZERO];
        pdown_d = hwdata[`CDWE_ST_PDOWN];
        tout_d = hwdata[`CDWE_ST_TOUT];
      end
      if (dpAddr_q == `CDWE_ADDR_FDATA) begin
        memWe = 1'b1;
        memWaddr = fileAddr_q;
        memWdata = hwdata[DW-1:0];
      end
    end
  end

  // Bus slave: writes complete with no wait, reads take two wait cycles
  always @* begin
    dpWrite_d = dpWrite_q;
    dpAddr_d = dpAddr_q;
    rdCnt_d = rdCnt_q;
    fileAddr_d = fileAddr_q;
    hrdata_d = hrdata_q;
    retireCnt_d = retireCnt_q;
    if (retire_d) begin
      retireCnt_d = retireCnt_q + 8'h01;
    end
    if (wrDo) begin
      dpWrite_d = 1'b0;
      if (dpAddr_q == `CDWE_ADDR_FADDR) begin
        fileAddr_d = hwdata[AW-1:0];
      end
    end
    if (rdCnt_q != 2'h0 && state_q == ST_IDLE && state_d == ST_IDLE) begin
      if (rdCnt_q == `CDWE_RD_WAIT) begin
        rdCnt_d = 2'h0;
        case (dpAddr_q)
          `CDWE_ADDR_INSTR: hrdata_d = {18'h00000, instr_q};
          `CDWE_ADDR_WREG: hrdata_d = {24'h000000, wReg_q};
          `CDWE_ADDR_STATUS: hrdata_d = {27'h0000000, tout_q, pdown_q,
                                         zero_q, 2'h0};
          `CDWE_ADDR_FADDR: hrdata_d = {25'h0000000, fileAddr_q};
          `CDWE_ADDR_FDATA: hrdata_d = {24'h000000, memRdata};
          `CDWE_ADDR_WDOG: hrdata_d = {16'h0000, wdogPre[7:0],
                                       wdogCnt[7:0]};
          `CDWE_ADDR_INFO: hrdata_d = {16'h0000, retireCnt_q, 7'h00,
                                       lastSkip_q};
          default: hrdata_d = 32'h00000000;
        endcase
      end else begin
        rdCnt_d = rdCnt_q + 2'h1;
      end
    end
    if (accept) begin
      dpAddr_d = haddr;
      dpWrite_d = hwrite & wordOk;
      rdCnt_d = (~hwrite & wordOk) ? 2'h1 : 2'h0;
    end
    hreadyout_d = (state_d == ST_IDLE) & (rdCnt_d == 2'h0);
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h00000000;
      hresp_q <= 1'b0;
      dpWrite_q <= 1'b0;
      dpAddr_q <= 32'h00000000;
      rdCnt_q <= 2'h0;
      state_q <= ST_IDLE;
      instr_q <= 14'h0000;
      wReg_q <= `CDWE_RST_WREG;
      fileAddr_q <= 7'h00;
      zero_q <= `CDWE_RST_ZERO;
      tout_q <= `CDWE_RST_TOUT;
      pdown_q <= `CDWE_RST_PDOWN;
      retire_q <= 1'b0;
      skipNop_q <= 1'b0;
      lastSkip_q <= 1'b0;
      retireCnt_q <= 8'h00;
    end else begin
      hreadyout_q <= hreadyout_d;
      hrdata_q <= hrdata_d;
      hresp_q <= 1'b0;
      dpWrite_q <= dpWrite_d;
      dpAddr_q <= dpAddr_d;
      rdCnt_q <= rdCnt_d;
      state_q <= state_d;
      instr_q <= instr_d;
      wReg_q <= wReg_d;
      fileAddr_q <= fileAddr_d;
      zero_q <= zero_d;
      tout_q <= tout_d;
      pdown_q <= pdown_d;
      retire_q <= retire_d;
      skipNop_q <= (state_d == ST_NOP); // RULE_08
      lastSkip_q <= lastSkip_d;
      retireCnt_q <= retireCnt_d;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign instrRetire = retire_q;
  assign skipNop = skipNop_q;
  assign zeroFlag = zero_q;
  assign timeoutFlag = tout_q;
  assign powerdownFlag = pdown_q;

endmodule

`default_nettype wire

// ---- rtl/cdwe_defs.vh ----
`ifndef CDWE_DEFS_VH
`define CDWE_DEFS_VH

// Register byte addresses
`define CDWE_ADDR_INSTR 32'h00000000
`define CDWE_ADDR_WREG 32'h00000004
`define CDWE_ADDR_STATUS 32'h00000008
`define CDWE_ADDR_FADDR 32'h0000000C
`define CDWE_ADDR_FDATA 32'h00000010
`define CDWE_ADDR_WDOG 32'h00000014
`define CDWE_ADDR_INFO 32'h00000018

// Status register fields and reset values
`define CDWE_ST_ZERO 2
`define CDWE_ST_PDOWN 3
`define CDWE_ST_TOUT 4
`define CDWE_RST_ZERO 1'h0
`define CDWE_RST_PDOWN 1'h1
`define CDWE_RST_TOUT 1'h1
`define CDWE_RST_WREG 8'h00

// Instruction fields and encodings
`define CDWE_OPC_HI 13
`define CDWE_OPC_LO 8
`define CDWE_DEST_BIT 7
`define CDWE_OPC_COMPL 6'h09
`define CDWE_OPC_DEC 6'h03
`define CDWE_OPC_DECSKIP 6'h0B
`define CDWE_OPC_WDCLR 14'h0064

// Widths and timing
`define CDWE_FADDR_W 7
`define CDWE_DATA_W 8
`define CDWE_PRE_W 8
`define CDWE_WDOG_W 8
`define CDWE_RD_WAIT 2'h2
`define CDWE_HSIZE_WORD 3'h2

`endif

// ---- rtl/cdwe_file_mem.v ----
`timescale 1ns/1ps
`default_nettype none

module cdwe_file_mem #(
  parameter ADDR_W = 7,
  parameter DATA_W = 8
) (
  input wire clk,
  input wire wrEn,
  input wire [ADDR_W-1:0] wrAddr,
  input wire [DATA_W-1:0] wrData,
  input wire [ADDR_W-1:0] rdAddr,
  output wire [DATA_W-1:0] rdData
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  reg [DATA_W-1:0] rdData_q;

  // Read returns the old contents when read and write meet
  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData_q <= mem[rdAddr];
  end

  assign rdData = rdData_q;

endmodule

`default_nettype wire

// ---- rtl/cdwe_watchdog.v ----
`timescale 1ns/1ps
`default_nettype none

module cdwe_watchdog #(
  parameter PRE_W = 8,
  parameter CNT_W = 8
) (
  input wire clk,
  input wire rstN,
  input wire clear,
  output wire [PRE_W-1:0] prescale,
  output wire [CNT_W-1:0] count
);

  reg [PRE_W-1:0] prescale_q;
  reg [CNT_W-1:0] count_q;
  wire tick;

  // Prescaler wrap gives a one-cycle enable to the counter
  assign tick = &prescale_q;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prescale_q <= {PRE_W{1'b0}};
      count_q <= {CNT_W{1'b0}};
    end else if (clear) begin
      prescale_q <= {PRE_W{1'b0}};
      count_q <= {CNT_W{1'b0}};
    end else begin
      prescale_q <= prescale_q + {{(PRE_W-1){1'b0}}, 1'b1};
      if (tick) begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign prescale = prescale_q;
  assign count = count_q;

endmodule

`default_nettype wire

// ---- tb/cdwe_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdwe_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic instrRetire,
  input wire logic skipNop,
  input wire logic zeroFlag,
  input wire logic timeoutFlag,
  input wire logic powerdownFlag
);
  logic instrWr_q;
  logic go;
  logic [5:0] opc;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Remembers an address phase aimed at the instruction register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instrWr_q <= 1'b0;
    end else if (hready) begin
      instrWr_q <= hsel && htrans[1] && hwrite && haddr == 32'h0;
    end
  end
  assign go = instrWr_q && hready;
  assign opc = hwdata[13:8];
  a_wdclr_flags: assert property (
    go && hwdata[13:0] == 14'h0064 |=>
    timeoutFlag && powerdownFlag && instrRetire)
    else $error("Watchdog clear did not retire with flags set");
  a_exec_time: assert property (
    go && (opc == 6'h09 || opc == 6'h03) |=>
    !instrRetire [*2] ##1 instrRetire)
    else $error("Complement or decrement retired at wrong cycle");
  a_exec_stall: assert property (
    go && (opc == 6'h09 || opc == 6'h03) |=>
    !hreadyout [*2] ##1 hreadyout)
    else $error("Bus stall length wrong during execution");
  a_dskip_time: assert property (
    go && opc == 6'h0B |=> !instrRetire [*2] ##1 (instrRetire ^ skipNop))
    else $error("Decrement-skip ended at wrong cycle");
  a_dskip_flags: assert property (
    go && opc == 6'h0B |=>
    ($stable(zeroFlag) && $stable(timeoutFlag)) [*4])
    else $error("Decrement-skip changed a status flag");
  a_skip_ends: assert property (
    skipNop |=> instrRetire && hreadyout && !skipNop)
    else $error("Skip cycle not followed by retirement");
  a_skip_stall: assert property (
    skipNop |-> !hreadyout && !instrRetire)
    else $error("Bus not stalled in skip cycle");
  a_retire_ready: assert property (
    $rose(instrRetire) |-> hreadyout)
    else $error("Retirement without bus release");
endmodule
bind cdwe_top cdwe_props u_props (.clk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .instrRetire, .skipNop,
  .zeroFlag, .timeoutFlag, .powerdownFlag);
`default_nettype wire

// ---- tb/cdwe_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cdwe_defs.vh"
module cdwe_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, instrRetire, skipNop;
  wire zeroFlag, timeoutFlag, powerdownFlag;
  int errorCnt = 0;
  int checkCount = 0;
  int skipSeen = 0;
  logic [31:0] rv;
  logic [7:0] w, fv, d, res;
  logic [6:0] a;
  logic [5:0] opc;
  logic dst, zf, toutExp, pdownExp, lsk;
  int op, nSkip;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (skipNop === 1'b1) skipSeen++;
  cdwe_top uut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .instrRetire, .skipNop, .zeroFlag, .timeoutFlag, .powerdownFlag);
  task automatic chk(input string n, input logic [31:0] s, e);
    checkCount++;
    if (s !== e) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [31:0] ad, wd,
    output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic printVerdict;
    if (errorCnt == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    printVerdict;
  end
  initial begin
    void'($urandom(32'h6B57));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    zf = 1'b0;
    toutExp = 1'b1;
    pdownExp = 1'b1;
    bus(1'b0, `CDWE_ADDR_STATUS, 32'h0, rv);
    chk("status", rv, {27'h0, toutExp, pdownExp, zf, 2'h0});
    for (int i = 0; i < 48; i++) begin
      op = i % 3;
      a = 7'($urandom % 128);
      d = (i % 4 == 0) ? 8'h01 : (i % 4 == 1) ? 8'h00 : 8'($urandom);
      w = 8'($urandom);
      dst = 1'($urandom);
      fv = d;
      opc = (op == 0) ? 6'h09 : (op == 1) ? 6'h03 : 6'h0B;
      res = (op == 0) ? ~d : d - 8'h01;
      if (op != 2) zf = (res == 8'h00);
      lsk = (op == 2 && res == 8'h00);
      if (dst) fv = res;
      else w = res;
      bus(1'b1, `CDWE_ADDR_FADDR, {25'h0, a}, rv);
      bus(1'b1, `CDWE_ADDR_FDATA, {24'h0, d}, rv);
      bus(1'b1, `CDWE_ADDR_WREG, {24'h0, dst ? w : ~res}, rv);
      nSkip = skipSeen;
      bus(1'b1, `CDWE_ADDR_INSTR, {18'h0, opc, dst, a}, rv);
      bus(1'b0, `CDWE_ADDR_WREG, 32'h0, rv);
      chk("wreg", rv, {24'h0, w});
      bus(1'b0, `CDWE_ADDR_FDATA, 32'h0, rv);
      chk("fdata", rv, {24'h0, fv});
      bus(1'b0, `CDWE_ADDR_STATUS, 32'h0, rv);
      chk("zero", rv, {27'h0, toutExp, pdownExp, zf, 2'h0});
      rv = {29'h0, zeroFlag, timeoutFlag, powerdownFlag};
      chk("pins", rv, {29'h0, zf, toutExp, pdownExp});
      chk("hresp", {31'h0, hresp}, 32'h0);
      chk("skips", skipSeen - nSkip, {31'h0, op == 2 && res == 0});
      bus(1'b0, `CDWE_ADDR_INFO, 32'h0, rv);
      chk("info", rv, {16'h0, 8'(i + 1), 7'h0, lsk});
    end
    bus(1'b1, `CDWE_ADDR_STATUS, 32'h0, rv);
    repeat (300) @(posedge clk);
    bus(1'b0, `CDWE_ADDR_WDOG, 32'h0, rv);
    chk("wdog run", {31'h0, rv[7:0] != 8'h00}, 32'h1);
    bus(1'b1, `CDWE_ADDR_INSTR, 32'h64, rv);
    bus(1'b0, `CDWE_ADDR_WDOG, 32'h0, rv);
    chk("wdog count", rv[7:0], 8'h00);
    chk("wdog pre", {31'h0, rv[15:8] < 8'h10}, 32'h1);
    bus(1'b0, `CDWE_ADDR_STATUS, 32'h0, rv);
    chk("wd status", rv, 32'h18);
    bus(1'b0, `CDWE_ADDR_INSTR, 32'h0, rv);
    chk("instr", rv, 32'h64);
    bus(1'b1, 32'h40, 32'hFF, rv);
    bus(1'b0, 32'h40, 32'h0, rv);
    chk("unmapped", rv, 32'h0);
    printVerdict;
  end
endmodule
`default_nettype wire
